// ### bench/prog_memory_model.sv
// Program memory model: 12-bit words answered at once from the program counter.
// Assumes the bench loads mem while the core is held in reset.
`timescale 1ns/100ps

module prog_memory_model (
  input wire logic [9:0] pc_i,
  output logic [11:0] instr_o
);
  logic [11:0] mem [1024];

  // Combinational read, as the core expects of its program store
  assign instr_o = mem[pc_i];
endmodule : prog_memory_model

// ### bench/test_twelve_bit_instruction_decoder.sv
// Self-checking bench for the instruction decoder: programs, AHB-Lite reads, port pins.
// Assumes a combinational program store and data file, both modelled here.
`timescale 1ns/100ps

module test_twelve_bit_instruction_decoder;
  logic core_clk_i, rst_i, hsel_i, hwrite_i, wake_i, hreadyout_o, hresp_o;
  logic prescaler_clear_o, wdt_clear_o, asleep_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [11:0] instr_i;
  logic [9:0] pc_o;
  decoder_pkg::file_req_t file_req_o;
  logic [7:0] file_rdata_i, option_o;
  logic [5:0] gpio_pin_i, gpio_o, gpio_oe_o;
  logic [7:0] file_mem [32];
  logic [11:0] prog [32];
  int miscompares, samples_checked, n_psc, n_wdt, cyc, t3, t6;
  localparam logic [5:0] OPC [14] = '{6'h07, 6'h02, 6'h05, 6'h04, 6'h06, 6'h03, 6'h0a,
                                      6'h09, 6'h08, 6'h0e, 6'h0d, 6'h0c, 6'h0b, 6'h0f};
  localparam logic [3:0] LIT [4] = '{4'he, 4'hd, 4'hf, 4'hc};
  localparam logic [11:0] FIX [4] = '{12'h068, 12'h040, 12'h028, 12'h000};

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  instruction_decoder #(.GPIO_W(6)) u_instruction_decoder (.hready_i(hreadyout_o), .*);
  prog_memory_model u_prog_memory_model (.pc_i(pc_o), .instr_o(instr_i));
  assign file_rdata_i = file_mem[file_req_o.addr];

  ////////////////////////////////////////////////////////////////////////
  // Data file, pulse counters and timing probes
  always @(posedge core_clk_i) begin
    cyc++;
    if (file_req_o.we === 1'b1) file_mem[file_req_o.addr] <= file_req_o.wdata;
    if (prescaler_clear_o === 1'b1) n_psc++;
    if (wdt_clear_o === 1'b1) n_wdt++;
    if (pc_o === 10'h003 && t3 < 0) t3 = cyc;
    if (pc_o === 10'h006 && t6 < 0) t6 = cyc;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Bounded wait for hready; a hung slave ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= addr;
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    hsize_i <= decoder_pkg::SIZE_WORD;
    wait_ready();
    htrans_i <= 2'b00;
    hsel_i <= 1'b0;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
  endtask : bus

  task automatic rd_check(input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    bus(1'b0, addr, 32'h0, rd);
    check(rd & mask, exp, what);
    check({31'h0, hresp_o}, 32'h0, "response");
  endtask : rd_check

  // Program is loaded under reset so no half-fetched word is executed
  task automatic restart;
    rst_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 32; i++) begin
      file_mem[i] = 8'h00;
      u_prog_memory_model.mem[i] = prog[i];
    end
    repeat (20) @(posedge core_clk_i);
    n_psc = 0;
    n_wdt = 0;
    t3 = -1;
    t6 = -1;
    rst_i <= 1'b0;
  endtask : restart

  // Expected W, file 8, flags {z,dc,c} and skip for one operation on f=a, W=b
  task automatic model(input int op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] k,
                       input logic d, output logic [11:0] word, output logic [7:0] w, output logic [7:0] f8,
                       output logic [2:0] st, output logic skip);
    logic [8:0] sum, dif;
    logic [13:0] v;
    sum = {1'b0, a} + {1'b0, b};
    dif = {1'b0, a} - {1'b0, b};
    case (op)
      0: v = {3'b111, sum[8], a[3:0] + b[3:0] > 5'h0f, sum};
      1: v = {3'b111, ~dif[8], a[3:0] >= b[3:0], dif};
      2: v = {5'h10, 1'b0, a & b};
      3: v = {5'h10, 1'b0, a | b};
      4: v = {5'h10, 1'b0, a ^ b};
      5, 12: v = {(op == 5), 5'h00, a - 8'h01};
      6, 13: v = {(op == 6), 5'h00, a + 8'h01};
      7: v = {5'h10, 1'b0, ~a};
      8: v = {5'h10, 1'b0, a};
      9: v = {5'h00, 1'b0, a[3:0], a[7:4]};
      10: v = {3'b001, a[7], 2'b00, a[6:0], 1'b0};
      11: v = {3'b001, a[0], 3'b000, a[7:1]};
      18: v = {5'h10, 1'b0, b & k};
      19: v = {5'h10, 1'b0, b | k};
      20: v = {5'h10, 1'b0, b ^ k};
      21: v = {5'h00, 1'b0, k};
      22, 23: v = {5'h10, 9'h000};
      default: v = 14'h0000;
    endcase
    if (op < 14) word = {OPC[op], d, 5'h08};
    else if (op < 18) word = {4'(op - 10), k[2:0], 5'h08};
    else if (op < 22) word = {LIT[op - 18], k};
    else word = FIX[op - 22];
    w = b;
    f8 = a;
    if (op < 14 && d) f8 = v[7:0];
    else if (op < 14 || op inside {[18:21], 23}) w = v[7:0];
    if (op == 22) f8 = 8'h00;
    if (op == 24) f8 = b;
    if (op == 14) f8 = a & ~(8'h01 << k[2:0]);
    if (op == 15) f8 = a | (8'h01 << k[2:0]);
    skip = (op == 12 || op == 13) && v[7:0] == 8'h00 || op == 16 && !a[k[2:0]] || op == 17 && a[k[2:0]];
    st = {v[13] & (v[7:0] == 8'h00), v[12] & v[9], v[11] & v[10]};
  endtask : model

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic [7:0] a, b, k, w, f8;
    logic [11:0] word;
    logic [2:0] st;
    logic d, skip;
    rst_i = 1'b1;
    {hsel_i, hwrite_i, wake_i} = 3'b000;
    {haddr_i, hwdata_i, htrans_i, gpio_pin_i} = '0;
    hsize_i = decoder_pkg::SIZE_WORD;
    {cyc, miscompares, samples_checked} = '0;
    for (int i = 0; i < 32; i++) prog[i] = 12'h000;
    void'($urandom(55));
    restart();
    check({26'h0, gpio_oe_o}, 32'h0, "oe after reset");
    rd_check(decoder_pkg::REG_CTRL, 32'h1, 32'h1, "ctrl reset");
    rd_check(decoder_pkg::REG_STATUS, 32'h3f, 32'h18, "status reset");
    rd_check(decoder_pkg::REG_DIR, 32'h3f, 32'h3f, "dir reset");
    bus(1'b1, decoder_pkg::REG_OPTION, 32'h5a, rd);
    rd_check(decoder_pkg::REG_OPTION, 32'hff, 32'hff, "option read-only");
    rd_check(32'h40, 32'hffffffff, 32'h0, "unmapped");
    bus(1'b1, decoder_pkg::REG_CTRL, 32'h0, rd);
    bus(1'b0, decoder_pkg::REG_PC, 32'h0, rd);
    repeat (16) @(posedge core_clk_i);
    rd_check(decoder_pkg::REG_PC, 32'h3ff, rd & 32'h3ff, "frozen pc");
    // Every operation but return, call, branch, option, direction, standby and watchdog clear, corner operands first, then random ones
    for (int pass = 0; pass < 4; pass++) begin
      for (int op = 0; op < 26; op++) begin
        a = pass == 0 ? 8'hff : pass == 1 ? 8'h01 : 8'($urandom);
        b = pass > 1 ? 8'($urandom) : 8'h01;
        k = 8'($urandom);
        d = 1'($urandom);
        model(op, a, b, k, d, word, w, f8, st, skip);
        prog[0:6] = '{{4'hc, a}, 12'h028, {4'hc, b}, word, 12'h509, 12'h000, 12'ha06};
        restart();
        repeat (60) @(posedge core_clk_i);
        rd_check(decoder_pkg::REG_WREG, 32'hff, {24'h0, w}, "w");
        rd_check(decoder_pkg::REG_STATUS, 32'h7, {29'h0, st}, "flags");
        check({24'h0, file_mem[8]}, {24'h0, f8}, "file");
        check({24'h0, file_mem[9]}, {31'h0, ~skip}, "skip");
        check(t6 - t3, 12, "cycles");
        rd_check(decoder_pkg::REG_PC, 32'h3ff, 32'h6, "pc");
      end
    end
    // Call, return with literal, then a port read taken from the pins
    gpio_pin_i <= 6'($urandom);
    prog[0:5] = '{12'hc3f, 12'h006, 12'h910, 12'h106, 12'h226, 12'ha05};
    prog[16] = 12'h877;
    restart();
    repeat (60) @(posedge core_clk_i);
    rd_check(decoder_pkg::REG_WREG, 32'hff, {24'h0, 8'h77 | {2'b00, gpio_pin_i}}, "pin read");
    check({26'h0, gpio_o}, {26'h0, gpio_pin_i}, "port write back");
    rd_check(decoder_pkg::REG_PC, 32'h3ff, 32'h5, "return pc");
    // Option, direction, timer clear, watchdog clear, standby, wake
    prog[0:6] = '{12'hc22, 12'h002, 12'h006, 12'h061, 12'h004, 12'h003, 12'ha06};
    restart();
    repeat (60) @(posedge core_clk_i);
    check({24'h0, option_o}, 32'h22, "option");
    check({26'h0, gpio_oe_o}, 32'h1d, "oe");
    check(n_psc, 1, "prescaler clears");
    check(n_wdt, 2, "watchdog clears");
    rd_check(decoder_pkg::REG_STATUS, 32'h3c, 32'h34, "standby status");
    wake_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check({31'h0, asleep_o}, 32'h0, "woken");
    report_and_stop();
  end
endmodule : test_twelve_bit_instruction_decoder

// ### hdl/instruction_decoder.sv
// Execution core for the 33-instruction, 12-bit word set.
// Assumes program memory answers pc_o combinationally on instr_i and the
// data file answers file_req_o.addr combinationally on file_rdata_i.
//
// Function
// - Byte results go to W when d is 0, back to the file when 1.
// - Add and file-minus-W update carry, digit carry and zero in one cycle.
// - AND, OR, XOR of W with file update only zero.
// - Decrement/increment set zero; skip forms change no flag, skip on zero.
// - Rotate left or right through carry, only carry changes, one cycle.
// - Bit test skips when bit clear or set, flags untouched, two cycles when it skips, one otherwise.
// - Literal AND, OR, XOR into W update only zero.
// - Literal load into W without flags; return pops and loads literal.
// - Every PC write except the branch forces PC bit 9 to zero.
// - Standby and watchdog clear update timeout and powerdown bits.
// - Option loads from W; direction load of index 6 copies W.
// - Port read-modify-write takes pin levels, not the output latch.
// - Flagged writes to the timer clear a timer-assigned prescaler.
// - Four oscillator periods per cycle; skips and jumps take two.
`timescale 1ns/100ps

module instruction_decoder #(
  parameter int GPIO_W = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [11:0] instr_i,
  output logic [9:0] pc_o,
  output decoder_pkg::file_req_t file_req_o,
  input wire logic [7:0] file_rdata_i,
  input wire logic [GPIO_W-1:0] gpio_pin_i,
  input wire logic wake_i,
  output logic [GPIO_W-1:0] gpio_o,
  output logic [GPIO_W-1:0] gpio_oe_o,
  output logic [7:0] option_o,
  output logic prescaler_clear_o,
  output logic wdt_clear_o,
  output logic asleep_o
);

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

  function automatic logic [9:0] add9(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    return {lo[4], full};
  endfunction : add9

  phase_t ph_q;
  logic run_q, asleep_q, flush_q;
  logic [11:0] ir_q;
  logic [9:0] pc_q, stack0_q, stack1_q;
  logic [7:0] wreg_q, option_q;
  logic [GPIO_W-1:0] gpio_q, dir_q;
  decoder_pkg::status_t status_q, fl;
  decoder_pkg::file_req_t file_q;
  logic [GPIO_W:0] pin_s1_q, pin_s2_q;
  logic wr_pend_q, pclr_q, wdtc_q;
  logic [31:0] wr_addr_q, hrdata_q;

  logic active, ex;
  decoder_pkg::byte_op_t op;
  logic [4:0] f_idx;
  logic [2:0] bsel;
  logic [7:0] src, res, mask;
  logic [9:0] sum, dif, jpc;
  logic wr_w, wr_f, zop, skip, jump, push, pop;
  logic opt_ld, dir_ld, slp, wdt, tmr_flag;

  assign active = run_q && !asleep_q;
  assign ex = active && ph_q == PH_Q4 && !flush_q;
  assign op = decoder_pkg::byte_op_t'(ir_q[11:6]);
  assign f_idx = ir_q[4:0];
  assign bsel = ir_q[7:5];
  assign mask = 8'h01 << bsel;

  ////////////////////////////////////////////////////////////////////////
  // Decode and execute
  always_comb begin
    // Port reads see the synchronised pins, not the latch
    if (f_idx == decoder_pkg::IDX_GPIO) begin
      src = 8'(pin_s2_q[GPIO_W-1:0]);
    end else if (f_idx == decoder_pkg::IDX_STATUS) begin
      src = {3'h0, status_q};
    end else begin
      src = file_rdata_i;
    end
    sum = add9(src, wreg_q, 1'b0);
    dif = add9(src, ~wreg_q, 1'b1);
    res = 8'h00;
    fl = status_q;
    wr_w = 1'b0;
    wr_f = 1'b0;
    zop = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    jpc = pc_q;
    push = 1'b0;
    pop = 1'b0;
    opt_ld = 1'b0;
    dir_ld = 1'b0;
    slp = 1'b0;
    wdt = 1'b0;
    tmr_flag = 1'b1;
    if (ir_q[11:10] == 2'b00) begin
      wr_w = !ir_q[5];
      wr_f = ir_q[5];
      unique case (op)
        decoder_pkg::OP_MISC: begin
          wr_w = 1'b0;
          res = wreg_q;
          if (ir_q == decoder_pkg::INS_OPTION) begin
            opt_ld = 1'b1;
          end else if (ir_q == decoder_pkg::INS_SLEEP) begin
            slp = 1'b1;
            fl.to = 1'b1;
            fl.pd = 1'b0;
          end else if (ir_q == decoder_pkg::INS_WDT_CLEAR) begin
            wdt = 1'b1;
            fl.to = 1'b1;
            fl.pd = 1'b1;
          end else if (ir_q == decoder_pkg::INS_DIR_LOAD) begin
            dir_ld = 1'b1;
          end
        end
        decoder_pkg::OP_CLR: zop = 1'b1;
        decoder_pkg::OP_SUB: begin
          {fl.dc, fl.c, res} = dif;
          zop = 1'b1;
        end
        decoder_pkg::OP_ADD: begin
          {fl.dc, fl.c, res} = sum;
          zop = 1'b1;
        end
        decoder_pkg::OP_DEC: begin
          res = src - 8'h01;
          zop = 1'b1;
        end
        decoder_pkg::OP_INC: begin
          res = src + 8'h01;
          zop = 1'b1;
        end
        decoder_pkg::OP_DECSKIP: begin
          res = src - 8'h01;
          skip = res == 8'h00;
        end
        decoder_pkg::OP_INCSKIP: begin
          res = src + 8'h01;
          skip = res == 8'h00;
        end
        decoder_pkg::OP_OR: begin
          res = wreg_q | src;
          zop = 1'b1;
        end
        decoder_pkg::OP_AND: begin
          res = wreg_q & src;
          zop = 1'b1;
        end
        decoder_pkg::OP_XOR: begin
          res = wreg_q ^ src;
          zop = 1'b1;
        end
        decoder_pkg::OP_MOVE: begin
          res = src;
          zop = 1'b1;
        end
        decoder_pkg::OP_COMP: begin
          res = ~src;
          zop = 1'b1;
          tmr_flag = 1'b0;
        end
        decoder_pkg::OP_RRC: begin
          res = {status_q.c, src[7:1]};
          fl.c = src[0];
        end
        decoder_pkg::OP_RLC: begin
          res = {src[6:0], status_q.c};
          fl.c = src[7];
        end
        decoder_pkg::OP_SWAP: res = {src[3:0], src[7:4]};
      endcase
    end else if (ir_q[11:10] == 2'b01) begin
      unique case (ir_q[11:8])
        decoder_pkg::BIT_CLEAR: begin
          res = src & ~mask;
          wr_f = 1'b1;
        end
        decoder_pkg::BIT_SET: begin
          res = src | mask;
          wr_f = 1'b1;
        end
        decoder_pkg::BIT_TEST_CLR: skip = (src & mask) == 8'h00;
        default: skip = (src & mask) != 8'h00;
      endcase
    end else begin
      res = ir_q[7:0];
      unique case (ir_q[11:8])
        decoder_pkg::LIT_RETURN: begin
          wr_w = 1'b1;
          pop = 1'b1;
          jump = 1'b1;
          jpc = {1'b0, stack0_q[8:0]};
        end
        decoder_pkg::LIT_CALL: begin
          push = 1'b1;
          jump = 1'b1;
          jpc = {2'b00, ir_q[7:0]};
        end
        {decoder_pkg::LIT_BRANCH, 1'b0}, {decoder_pkg::LIT_BRANCH, 1'b1}: begin
          jump = 1'b1;
          jpc = {pc_q[9], ir_q[8:0]};
        end
        decoder_pkg::LIT_LOAD: wr_w = 1'b1;
        decoder_pkg::LIT_OR: begin
          res = wreg_q | ir_q[7:0];
          wr_w = 1'b1;
          zop = 1'b1;
        end
        decoder_pkg::LIT_AND: begin
          res = wreg_q & ir_q[7:0];
          wr_w = 1'b1;
          zop = 1'b1;
        end
        default: begin
          res = wreg_q ^ ir_q[7:0];
          wr_w = 1'b1;
          zop = 1'b1;
        end
      endcase
    end
    if (zop) begin
      fl.z = res == 8'h00;
    end
    if (wr_f && f_idx == decoder_pkg::IDX_PCL) begin
      jump = 1'b1;
      jpc = {2'b00, res};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction cycle sequencing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q <= PH_Q1;
    end else if (active) begin
      unique case (ph_q)
        PH_Q1: ph_q <= PH_Q2;
        PH_Q2: ph_q <= PH_Q3;
        PH_Q3: ph_q <= PH_Q4;
        PH_Q4: ph_q <= PH_Q1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_q <= decoder_pkg::INS_NOP;
      flush_q <= 1'b0;
      pc_q <= decoder_pkg::PC_RST;
      stack0_q <= decoder_pkg::PC_RST;
      stack1_q <= decoder_pkg::PC_RST;
    end else begin
      if (active && ph_q == PH_Q1) begin
        ir_q <= instr_i;
      end
      if (active && ph_q == PH_Q4) begin
        // A taken skip or jump leaves the next cycle idle
        flush_q <= ex && (skip || jump);
      end
      if (ex) begin
        pc_q <= jump ? jpc : pc_q + (skip ? 10'd2 : 10'd1);
        if (push) begin
          stack1_q <= stack0_q;
          stack0_q <= pc_q + 10'd1;
        end else if (pop) begin
          stack0_q <= stack1_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Architectural state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wreg_q <= decoder_pkg::WREG_RST;
      status_q <= decoder_pkg::STATUS_RST;
      option_q <= decoder_pkg::OPTION_RST;
      dir_q <= '1;
      gpio_q <= '0;
    end else if (ex) begin
      status_q <= fl;
      if (wr_w) begin
        wreg_q <= res;
      end
      if (opt_ld) begin
        option_q <= wreg_q;
      end
      if (dir_ld) begin
        dir_q <= wreg_q[GPIO_W-1:0];
      end
      if (wr_f && f_idx == decoder_pkg::IDX_GPIO) begin
        gpio_q <= res[GPIO_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      file_q <= '0;
      pclr_q <= 1'b0;
      wdtc_q <= 1'b0;
      asleep_q <= 1'b0;
    end else begin
      file_q.we <= ex && wr_f && f_idx != decoder_pkg::IDX_PCL && f_idx != decoder_pkg::IDX_STATUS
                   && f_idx != decoder_pkg::IDX_GPIO;
      if (active && ph_q == PH_Q1) begin
        file_q.addr <= instr_i[4:0];
      end
      if (ex) begin
        file_q.wdata <= res;
      end
      pclr_q <= ex && wr_f && tmr_flag && f_idx == decoder_pkg::IDX_TIMER
                && !option_q[decoder_pkg::OPT_PSA];
      wdtc_q <= ex && (slp || wdt);
      // Wake is a level; sleep entered while it is high ends one clock later
      if (ex && slp) begin
        asleep_q <= 1'b1;
      end else if (pin_s2_q[GPIO_W]) begin
        asleep_q <= 1'b0;
      end
    end
  end

  // Pins and wake come from outside the clock domain
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {wake_i, gpio_pin_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus slave, zero wait states
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
      run_q <= decoder_pkg::RUN_RST;
    end else begin
      wr_pend_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i && hsize_i == decoder_pkg::SIZE_WORD;
      wr_addr_q <= haddr_i;
      if (wr_pend_q && wr_addr_q == decoder_pkg::REG_CTRL) begin
        run_q <= hwdata_i[0];
      end
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
        case (haddr_i)
          decoder_pkg::REG_CTRL: hrdata_q <= {31'h0, run_q};
          decoder_pkg::REG_WREG: hrdata_q <= {24'h0, wreg_q};
          decoder_pkg::REG_STATUS: hrdata_q <= {26'h0, asleep_q, status_q};
          decoder_pkg::REG_OPTION: hrdata_q <= {24'h0, option_q};
          decoder_pkg::REG_DIR: hrdata_q <= 32'(dir_q);
          decoder_pkg::REG_PC: hrdata_q <= {22'h0, pc_q};
          default: hrdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;
  assign pc_o = pc_q;
  assign file_req_o = file_q;
  assign gpio_o = gpio_q;
  assign gpio_oe_o = ~dir_q;
  assign option_o = option_q;
  assign prescaler_clear_o = pclr_q;
  assign wdt_clear_o = wdtc_q;
  assign asleep_o = asleep_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_jump;
    ex && jump;
  endsequence

  logic byte_grp;
  assign byte_grp = ir_q[11:10] == 2'b00;

  dest_route_a: assert property (ex && byte_grp && op == decoder_pkg::OP_ADD && !ir_q[5]
    |=> wreg_q == $past(sum[7:0]) && !file_req_o.we) else $error("add result not in W");
  add_flags_a: assert property (ex && byte_grp && op == decoder_pkg::OP_ADD
    |=> status_q.c == $past(sum[8]) && status_q.dc == $past(sum[9])) else $error("add flags wrong");
  logic_zero_a: assert property (ex && byte_grp && op == decoder_pkg::OP_AND
    |=> status_q.c == $past(status_q.c) && status_q.z == (($past(wreg_q) & $past(src)) == 8'h00))
    else $error("and flags");
  dec_skip_a: assert property (ex && byte_grp && op == decoder_pkg::OP_DECSKIP && src == 8'h01
    |=> flush_q && status_q == $past(status_q)) else $error("dec skip missed");
  rotate_carry_a: assert property (ex && byte_grp && op == decoder_pkg::OP_RLC
    |=> status_q.c == $past(src[7])) else $error("rotate carry wrong");
  bit_skip_a: assert property (ex && ir_q[11:8] == decoder_pkg::BIT_TEST_SET && src[bsel]
    |=> flush_q ##4 !flush_q || !active) else $error("bit test skip wrong");
  lit_and_a: assert property (ex && ir_q[11:8] == decoder_pkg::LIT_AND
    |=> wreg_q == ($past(wreg_q) & $past(ir_q[7:0]))) else $error("literal and wrong");
  ret_pop_a: assert property (ex && ir_q[11:8] == decoder_pkg::LIT_RETURN
    |=> pc_q == {1'b0, $past(stack0_q[8:0])} && wreg_q == $past(ir_q[7:0])) else $error("return wrong");
  call_bit9_a: assert property (ex && ir_q[11:8] == decoder_pkg::LIT_CALL
    |=> pc_q == {2'b00, $past(ir_q[7:0])} && stack0_q == $past(pc_q) + 10'd1) else $error("call wrong");
  branch_keep_a: assert property (ex && ir_q[11:9] == decoder_pkg::LIT_BRANCH
    |=> pc_q == {$past(pc_q[9]), $past(ir_q[8:0])}) else $error("branch target wrong");
  sleep_bits_a: assert property (ex && ir_q == decoder_pkg::INS_SLEEP
    |=> status_q.to && !status_q.pd && wdt_clear_o ##1 !wdt_clear_o) else $error("sleep bits wrong");
  dir_load_a: assert property (ex && ir_q == decoder_pkg::INS_DIR_LOAD
    |=> gpio_oe_o == ~$past(wreg_q[GPIO_W-1:0])) else $error("direction load wrong");
  pin_source_a: assert property (ex && ir_q[11:5] == 7'h11 && f_idx == decoder_pkg::IDX_GPIO
    |=> gpio_o == $past(pin_s2_q[GPIO_W-1:0])) else $error("port source not pins");
  prescale_clr_a: assert property (ex && ir_q[11:5] == 7'h03 && f_idx == decoder_pkg::IDX_TIMER
    && !option_q[decoder_pkg::OPT_PSA] |=> prescaler_clear_o ##1 !prescaler_clear_o) else $error("prescaler kept");
  clear_zero_a: assert property (ex && byte_grp && op == decoder_pkg::OP_CLR
    |=> status_q.z) else $error("clear left zero low");
  bit_set_a: assert property (ex && ir_q[11:8] == decoder_pkg::BIT_SET
    |=> status_q == $past(status_q) && !flush_q) else $error("bit set side effect");
  jump_idle_a: assert property (s_jump |=> flush_q [*4]) else $error("jump not two cycles");
  cycle_len_a: assert property (ex |=> !ex [*3]) else $error("cycle shorter than four");

endmodule : instruction_decoder

// ### include/decoder_pkg.sv
// Constants and carriers for the twelve-bit instruction decoder core.
// Assumes a single core clock that doubles as the oscillator period.
package decoder_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CORE_CLK_MHZ = 25;
  localparam int OSC_PER_CYCLE = 4;
  // One core clock stands for one oscillator period
  localparam int CYCLE_CLKS = OSC_PER_CYCLE * CORE_CLK_MHZ / CORE_CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////
  // Special file indices
  localparam logic [4:0] IDX_TIMER = 5'h01;
  localparam logic [4:0] IDX_PCL = 5'h02;
  localparam logic [4:0] IDX_STATUS = 5'h03;
  localparam logic [4:0] IDX_GPIO = 5'h06;

  // Whole-word control instructions
  localparam logic [11:0] INS_NOP = 12'h000;
  localparam logic [11:0] INS_OPTION = 12'h002;
  localparam logic [11:0] INS_SLEEP = 12'h003;
  localparam logic [11:0] INS_WDT_CLEAR = 12'h004;
  localparam logic [11:0] INS_DIR_LOAD = 12'h006;

  // Byte-oriented opcodes, instruction bits 11:6
  typedef enum logic [5:0] {
    OP_MISC = 6'h00, OP_CLR = 6'h01, OP_SUB = 6'h02, OP_DEC = 6'h03,
    OP_OR = 6'h04, OP_AND = 6'h05, OP_XOR = 6'h06, OP_ADD = 6'h07,
    OP_MOVE = 6'h08, OP_COMP = 6'h09, OP_INC = 6'h0a, OP_DECSKIP = 6'h0b,
    OP_RRC = 6'h0c, OP_RLC = 6'h0d, OP_SWAP = 6'h0e, OP_INCSKIP = 6'h0f
  } byte_op_t;

  // Bit and literal opcodes, instruction bits 11:8
  localparam logic [3:0] BIT_CLEAR = 4'h4;
  localparam logic [3:0] BIT_SET = 4'h5;
  localparam logic [3:0] BIT_TEST_CLR = 4'h6;
  localparam logic [3:0] BIT_TEST_SET = 4'h7;
  localparam logic [3:0] LIT_RETURN = 4'h8;
  localparam logic [3:0] LIT_CALL = 4'h9;
  // Branch is decoded on bits 11:9 alone, bit 8 belongs to its target
  localparam logic [2:0] LIT_BRANCH = 3'h5;
  localparam logic [3:0] LIT_LOAD = 4'hc;
  localparam logic [3:0] LIT_OR = 4'hd;
  localparam logic [3:0] LIT_AND = 4'he;
  localparam logic [3:0] LIT_XOR = 4'hf;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_WREG = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS = 32'h0000_0008;
  localparam logic [31:0] REG_OPTION = 32'h0000_000c;
  localparam logic [31:0] REG_DIR = 32'h0000_0010;
  localparam logic [31:0] REG_PC = 32'h0000_0014;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // Reset values and field positions
  localparam logic RUN_RST = 1'b1;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [9:0] PC_RST = 10'h000;
  localparam int OPT_PSA = 3;

  // Status layout: bit 4 timeout .. bit 0 carry
  typedef struct packed {
    logic to;
    logic pd;
    logic z;
    logic dc;
    logic c;
  } status_t;

  localparam status_t STATUS_RST = 5'h18;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } file_req_t;

endpackage : decoder_pkg
